// ### core/atsc_pkg.sv
// package: register map, field positions and reset values of the trigger/suspend control block
package atsc_pkg;
	localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
	localparam logic [3:0]  STATUS_OFFSET  = 4'h4;
	localparam logic [3:0]  MASK_OFFSET    = 4'h8;
	localparam int          REF_SELECT_LSB = 13;
	localparam int          SUSPEND_BIT    = 12;
	localparam int          SUSP_IE_BIT    = 11;
	localparam int          SUSP_FLAG_BIT  = 10;
	localparam int          DIRECT_BIT     = 9;
	localparam int          SINGLE_BIT     = 8;
	localparam int          LEVEL_BIT      = 7;
	localparam int          COMMON_BIT     = 6;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_WMASK     = 16'hFBFF;
	localparam logic [2:0]  REF_SELECT_SUPPLY = 3'h0;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	localparam int          EV_SUSPENDED   = 0;
	localparam int          EV_SINGLE      = 1;
	localparam int          EV_COMMON      = 2;
	localparam int          EV_COUNT       = 3;
	localparam logic [2:0]  STATUS_RESET   = 3'h0;
endpackage : atsc_pkg

// ### core/atsc_rise_pulse.sv
// rising-edge detector: one-cycle pulse when a level goes high
`timescale 1ns/1ps
`default_nettype none
module atsc_rise_pulse (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic level,
	output var  logic pulse
);
	logic prev;
	logic next_prev;
	logic next_pulse;

	always_comb begin
		next_prev  = level;
		next_pulse = level & ~prev;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prev  <= 1'b0;
			pulse <= 1'b0;
		end else begin
			prev  <= next_prev;
			pulse <= next_pulse;
		end
	end
endmodule : atsc_rise_pulse
`default_nettype wire

// ### core/atsc_trigger_suspend.sv
// top: control register, trigger gating, suspend tracking and interrupt of the converter
// Notes on behaviour
// - the reference select field at bits 15..13 picks supply/ground at zero, other codes are unsupported.
// - while suspend (bit 12) is set every new trigger to every core is blocked.
// - the suspended flag (bit 10) is set only when suspend is on and no core is converting.
// - with the suspend interrupt enable (bit 11) set, suspension completion raises the interrupt; the code also needs bit 0 of the mask register set.
// - while direct sampling (bit 9) is set the shared core samples the selected channel.
// - with direct sampling clear the shared core times its own sampling.
// - writing one to bit 8 gives one trigger for the selected channel and the bit self-clears next cycle.
// - while bit 7 is set, triggers are produced continuously for level-trigger channels.
// - writing one to bit 6 gives one common trigger and the bit self-clears next cycle.
// - bits 5..0 name the channel converted by the single-channel trigger.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module atsc_trigger_suspend (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        coreBusy,
	input  wire logic        convStart,
	output var  logic        singleTrigger,
	output var  logic [5:0]  singleChannel,
	output var  logic        commonTrigger,
	output var  logic        levelTrigger,
	output var  logic        sharedSampleHold,
	output var  logic        refSupplySelected,
	output var  logic        irq
);
	// ==========================================================================
	// register state
	logic [15:0]                    ctrl;
	logic [15:0]                    next_ctrl;
	logic [atsc_pkg::EV_COUNT-1:0]  status;
	logic [atsc_pkg::EV_COUNT-1:0]  next_status;
	logic [atsc_pkg::EV_COUNT-1:0]  mask;
	logic [atsc_pkg::EV_COUNT-1:0]  next_mask;
	logic                           suspended;
	logic                           next_suspended;
	logic                           suspRise;

	// ==========================================================================
	// bus handshake state
	logic        awHeld;
	logic        next_awHeld;
	logic [3:0]  awAddr;
	logic [3:0]  next_awAddr;
	logic        wHeld;
	logic        next_wHeld;
	logic [31:0] wData;
	logic [31:0] next_wData;
	logic [3:0]  wStrb;
	logic [3:0]  next_wStrb;
	logic        next_awready;
	logic        next_wready;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        doWrite;
	logic [15:0] wMerged;
	logic [15:0] ctrlView;

	// ==========================================================================
	// output state
	logic        next_singleTrigger;
	logic        next_commonTrigger;
	logic        next_levelTrigger;
	logic        next_irq;

	always_comb begin
		ctrlView = ctrl;
		ctrlView[atsc_pkg::SUSP_FLAG_BIT] = suspended;
		wMerged = ctrl;
		if (wStrb[0]) begin
			wMerged[7:0] = wData[7:0];
		end
		if (wStrb[1]) begin
			wMerged[15:8] = wData[15:8];
		end
	end

	// ==========================================================================
	// AXI4-Lite slave: address and data taken in either order, response two cycles after both
	always_comb begin
		next_awHeld  = awHeld;
		next_awAddr  = awAddr;
		next_wHeld   = wHeld;
		next_wData   = wData;
		next_wStrb   = wStrb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		doWrite      = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (awHeld && wHeld && !s_axi_bvalid) begin
			doWrite     = 1'b1;
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = (awAddr == atsc_pkg::CTRL_OFFSET || awAddr == atsc_pkg::STATUS_OFFSET
				|| awAddr == atsc_pkg::MASK_OFFSET) ? atsc_pkg::RESP_OKAY : atsc_pkg::RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_awHeld && !next_bvalid;
		next_wready  = !next_wHeld && !next_bvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = atsc_pkg::RESP_OKAY;
			case (s_axi_araddr)
				atsc_pkg::CTRL_OFFSET: begin
					next_rdata = {16'h0000, ctrlView};
				end
				atsc_pkg::STATUS_OFFSET: begin
					next_rdata = {29'h0000000, status};
				end
				atsc_pkg::MASK_OFFSET: begin
					next_rdata = {29'h0000000, mask};
				end
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = atsc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid && !(s_axi_arvalid && s_axi_arready);
	end

	// ==========================================================================
	// control register and trigger generation
	always_comb begin
		next_ctrl = ctrl;
		next_mask = mask;
		// one-shot bits self-clear the cycle after they are set
		next_ctrl[atsc_pkg::SINGLE_BIT] = 1'b0;
		next_ctrl[atsc_pkg::COMMON_BIT] = 1'b0;
		if (doWrite && awAddr == atsc_pkg::CTRL_OFFSET) begin
			next_ctrl = (wMerged & atsc_pkg::CTRL_WMASK);
		end
		if (doWrite && awAddr == atsc_pkg::MASK_OFFSET && wStrb[0]) begin
			next_mask = wData[atsc_pkg::EV_COUNT-1:0];
		end
		// new triggers blocked while suspended; a one-shot bit (8 or 6) written during suspend is simply dropped, bit 7 stays set
		next_singleTrigger = ctrl[atsc_pkg::SINGLE_BIT] & ~ctrl[atsc_pkg::SUSPEND_BIT];
		next_commonTrigger = ctrl[atsc_pkg::COMMON_BIT] & ~ctrl[atsc_pkg::SUSPEND_BIT];
		next_levelTrigger  = ctrl[atsc_pkg::LEVEL_BIT] & ~ctrl[atsc_pkg::SUSPEND_BIT];
	end

	// ==========================================================================
	// suspend tracking and interrupt
	always_comb begin
		// dropping on a start covers a conversion already in flight when suspend was set
		next_suspended = ctrl[atsc_pkg::SUSPEND_BIT] & ~coreBusy & ~convStart;
		next_status = status;
		if (doWrite && awAddr == atsc_pkg::STATUS_OFFSET && wStrb[0]) begin
			next_status = status & ~wData[atsc_pkg::EV_COUNT-1:0];
		end
		// set wins over a clear in the same cycle
		next_status[atsc_pkg::EV_SUSPENDED] = next_status[atsc_pkg::EV_SUSPENDED] | suspRise;
		next_status[atsc_pkg::EV_SINGLE]    = next_status[atsc_pkg::EV_SINGLE] | singleTrigger;
		next_status[atsc_pkg::EV_COMMON]    = next_status[atsc_pkg::EV_COMMON] | commonTrigger;
		next_irq = |(status & mask & {{(atsc_pkg::EV_COUNT-1){1'b1}}, ctrl[atsc_pkg::SUSP_IE_BIT]});
	end

	atsc_rise_pulse suspEdge (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.level   (suspended),
		.pulse   (suspRise)
	);

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl              <= atsc_pkg::CTRL_RESET;
			status            <= atsc_pkg::STATUS_RESET;
			mask              <= atsc_pkg::STATUS_RESET;
			suspended         <= 1'b0;
			awHeld            <= 1'b0;
			awAddr            <= 4'h0;
			wHeld             <= 1'b0;
			wData             <= 32'h00000000;
			wStrb             <= 4'h0;
			s_axi_awready     <= 1'b0;
			s_axi_wready      <= 1'b0;
			s_axi_bvalid      <= 1'b0;
			s_axi_bresp       <= 2'h0;
			s_axi_arready     <= 1'b0;
			s_axi_rvalid      <= 1'b0;
			s_axi_rdata       <= 32'h00000000;
			s_axi_rresp       <= 2'h0;
			singleTrigger     <= 1'b0;
			singleChannel     <= 6'h00;
			commonTrigger     <= 1'b0;
			levelTrigger      <= 1'b0;
			sharedSampleHold  <= 1'b0;
			refSupplySelected <= 1'b1;
			irq               <= 1'b0;
		end else begin
			ctrl              <= next_ctrl;
			status            <= next_status;
			mask              <= next_mask;
			suspended         <= next_suspended;
			awHeld            <= next_awHeld;
			awAddr            <= next_awAddr;
			wHeld             <= next_wHeld;
			wData             <= next_wData;
			wStrb             <= next_wStrb;
			s_axi_awready     <= next_awready;
			s_axi_wready      <= next_wready;
			s_axi_bvalid      <= next_bvalid;
			s_axi_bresp       <= next_bresp;
			s_axi_arready     <= next_arready;
			s_axi_rvalid      <= next_rvalid;
			s_axi_rdata       <= next_rdata;
			s_axi_rresp       <= next_rresp;
			singleTrigger     <= next_singleTrigger;
			singleChannel     <= ctrl[5:0];
			commonTrigger     <= next_commonTrigger;
			levelTrigger      <= next_levelTrigger;
			// hardware never clears this bit; when low the core times its own sampling
			sharedSampleHold  <= ctrl[atsc_pkg::DIRECT_BIT];
			refSupplySelected <= (ctrl[15:atsc_pkg::REF_SELECT_LSB] == atsc_pkg::REF_SELECT_SUPPLY);
			irq               <= next_irq;
		end
	end
endmodule : atsc_trigger_suspend
`default_nettype wire

// ### test/atsc_trigger_suspend_props.sv
// checker: bus timing, reset levels and trigger pulse shape of the trigger/suspend block
`timescale 1ns/1ps
`default_nettype none
module atsc_trigger_suspend_props (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        singleTrigger,
	input wire logic        commonTrigger,
	input wire logic        levelTrigger,
	input wire logic        refSupplySelected,
	input wire logic        irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// ==========
	// assertions
	single_pulse_a: assert property (singleTrigger |=> !singleTrigger)
		else $error("single trigger wider than one cycle");
	common_pulse_a: assert property (commonTrigger |=> !commonTrigger)
		else $error("common trigger wider than one cycle");
	reset_out_a: assert property (disable iff (1'b0) !reset_n |=> refSupplySelected && !irq && !singleTrigger)
		else $error("outputs wrong after reset");
	write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before taken");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");
	cover property (singleTrigger);
	cover property (commonTrigger);
	cover property ($rose(irq));
	cover property (levelTrigger);
endmodule : atsc_trigger_suspend_props

bind atsc_trigger_suspend atsc_trigger_suspend_props i_atsc_trigger_suspend_props (.*);
`default_nettype wire

// ### test/testbench.sv
// testbench: register, trigger and suspend scenarios of the trigger/suspend block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int         LIM = 200;
	localparam logic [1:0] OK  = atsc_pkg::RESP_OKAY;
	localparam logic [3:0] CT  = atsc_pkg::CTRL_OFFSET;
	localparam logic [3:0] ST  = atsc_pkg::STATUS_OFFSET;
	localparam logic [3:0] MK  = atsc_pkg::MASK_OFFSET;
	logic        clk_sys = 1'b0, reset_n = 1'b0, coreBusy = 1'b0, convStart = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, rnd = 32'h15EF5AF1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        singleTrigger, commonTrigger, levelTrigger, sharedSampleHold, refSupplySelected, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [5:0]  singleChannel, lastChan = 6'h0;
	logic [33:0] expq[$];
	int          n_errors = 0, comparisons = 0, nSingle = 0, nCommon = 0;

	atsc_trigger_suspend i_atsc_trigger_suspend (.*);

	always #2 clk_sys = ~clk_sys;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test

	task automatic time_out();
		n_errors++;
		finish_test();
	endtask : time_out

	// ==========
	// bus master; ready lines are registers, so their negedge value is the one the next edge sees
	// bready/rready go up with the request and stay up until the answer is taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int   i;
		logic aw, w, b, awPend, wPend, bPend;
		expq.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		awPend = 1'b1;
		wPend = 1'b1;
		bPend = 1'b1;
		for (i = 0; i < LIM && bPend; i++) begin
			@(negedge clk_sys);
			aw = awPend && s_axi_awready;
			w = wPend && s_axi_wready;
			b = s_axi_bvalid;
			@(posedge clk_sys);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
			awPend = awPend && !aw;
			wPend = wPend && !w;
			bPend = !b;
		end
		if (bPend) time_out();
		// outputs that follow the written register settle within two edges
		repeat (2) @(posedge clk_sys);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int   i;
		logic ar, rv, arPend, rPend;
		expq.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		arPend = 1'b1;
		rPend = 1'b1;
		for (i = 0; i < LIM && rPend; i++) begin
			@(negedge clk_sys);
			ar = arPend && s_axi_arready;
			rv = s_axi_rvalid;
			@(posedge clk_sys);
			if (ar) s_axi_arvalid <= 1'b0;
			if (rv) s_axi_rready <= 1'b0;
			arPend = arPend && !ar;
			rPend = !rv;
		end
		if (rPend) time_out();
	endtask : rd

	// ==========
	// output monitor: trigger counts and oldest queued bus answer
	always @(posedge clk_sys) begin
		if (singleTrigger === 1'b1) begin
			nSingle++;
			lastChan = singleChannel;
		end
		if (commonTrigger === 1'b1) nCommon++;
		if (reset_n && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
			if (expq.size() == 0) chk(34'h0, 34'h1);
			else chk(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, expq.pop_front());
		end
	end

	initial begin
		logic [5:0] ch;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd(CT, {16'h0, atsc_pkg::CTRL_RESET}, OK);
		rd(ST, 32'h0, OK);
		rd(4'hC, 32'h0, atsc_pkg::RESP_SLVERR);
		wr(4'hC, 32'hFFFF, atsc_pkg::RESP_SLVERR);
		for (int k = 1; k <= 4; k++) begin
			rnd = lfsr(rnd);
			ch = rnd[5:0];
			wr(CT, {23'h0, 1'b1, 2'h0, ch}, OK);
			chk(nSingle, k);
			chk(lastChan, ch);
			rd(CT, {26'h0, ch}, OK);
		end
		wr(CT, 32'h40, OK);
		rd(CT, 32'h0, OK);
		chk(nCommon, 1);
		wr(CT, 32'h80, OK);
		chk(levelTrigger, 1'b1);
		wr(ST, 32'h7, OK);
		wr(MK, 32'h1, OK);
		rd(MK, 32'h1, OK);
		coreBusy <= 1'b1;
		wr(CT, 32'h1880, OK);
		rd(CT, 32'h1880, OK);
		chk(levelTrigger, 1'b0);
		wr(CT, 32'h1985, OK);
		rd(CT, 32'h1885, OK);
		chk(nSingle, 4);
		coreBusy <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rd(CT, 32'h1C85, OK);
		chk(irq, 1'b1);
		rd(ST, 32'h1, OK);
		wr(ST, 32'h1, OK);
		repeat (3) @(posedge clk_sys);
		chk(irq, 1'b0);
		coreBusy <= 1'b1;
		convStart <= 1'b1;
		@(posedge clk_sys);
		convStart <= 1'b0;
		rd(CT, 32'h1885, OK);
		coreBusy <= 1'b0;
		wr(CT, 32'h0, OK);
		rd(CT, 32'h0, OK);
		wr(ST, 32'h1, OK);
		wr(CT, 32'h1000, OK);
		repeat (5) @(posedge clk_sys);
		rd(ST, 32'h1, OK);
		chk(irq, 1'b0);
		wr(CT, 32'h205, OK);
		chk(sharedSampleHold, 1'b1);
		wr(CT, 32'h5, OK);
		chk(sharedSampleHold, 1'b0);
		wr(CT, 32'h105, OK);
		chk(nSingle, 5);
		chk(lastChan, 6'h05);
		wr(CT, 32'hA000, OK);
		chk(sharedSampleHold, 1'b0);
		rd(CT, 32'hA000, OK);
		chk(refSupplySelected, 1'b0);
		wr(CT, 32'h0, OK);
		chk(refSupplySelected, 1'b1);
		// only byte lane 1 enabled: the low byte must stay untouched
		s_axi_wstrb <= 4'h2;
		wr(CT, 32'h20A5, OK);
		s_axi_wstrb <= 4'hF;
		rd(CT, 32'h2000, OK);
		chk(refSupplySelected, 1'b0);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
